//--- logic/jsfa_top.sv
// JTAG TAP with SPI flash access sequencer
`timescale 1ns/1ps
`include "jsfa_params.svh"
module jsfa_top
   import jsfa_pkg::*;
#(
   parameter int SPI_HALF = `JSFA_SPI_HALF,
   parameter int FILE_WORDS = `JSFA_FILE_WORDS
) (
   // Oscillator clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // JTAG port
   input wire logic jtag_tck_i,
   input wire logic jtag_tms_i,
   input wire logic jtag_tdi_i,
   output logic jtag_tdo_o,
   output logic jtag_tdo_oe_o,
   // Configuration pins
   input wire logic [1:0] config_mode_pins_i,
   input wire logic active_controller_select_i,
   // SPI flash bus
   input wire logic spi_miso_i,
   output logic spi_clk_o,
   output logic spi_cs_n_o,
   output logic spi_mosi_o,
   output logic spi_oe_o,
   // Status
   output logic spi_busy_o
);

   localparam int FAW = $clog2(FILE_WORDS);

   // ----------------------------------------------------------------------
   // JTAG side (test clock domain)
   // ----------------------------------------------------------------------
   jsfa_tap_e tap_r;
   logic [`JSFA_IR_W-1:0] ir_r;
   logic [`JSFA_IR_W-1:0] ir_sh_r;
   logic [`JSFA_DESC_W-1:0] dr_r;
   logic [`JSFA_DESC_W-1:0] desc_raw_r;
   logic start_tgl_r;
   logic prev_access_r;
   logic [FAW-1:0] waddr_r;
   logic [31:0] file_mem [FILE_WORDS];
   logic done_tgl_t;
   logic busy_t;
   jsfa_desc_s desc;

   // ----------------------------------------------------------------------
   // Sequencer side (oscillator domain)
   // ----------------------------------------------------------------------
   jsfa_seq_e sq_r;
   logic [2:0] phase_r;
   logic [5:0] bit_cnt_r;
   logic [6:0] word_cnt_r;
   logic [FAW-1:0] word_idx_r;
   logic [63:0] sh_r;
   logic [7:0] half_r;
   logic [31:0] rx_r;
   logic start_seen_r;
   logic done_tgl_r;
   logic start_s;
   logic [2:0] pins_s;
   logic miso_s;
   logic half_end;
   logic cpol;
   logic cpha;

   assign desc = jsfa_desc_s'(desc_raw_r);
   assign busy_t = start_tgl_r ^ done_tgl_t;
   assign cpol = pins_s[2];
   assign cpha = pins_s[1];
   assign half_end = (half_r == 8'(SPI_HALF - 1));

   // TAP next-state decode
   function automatic jsfa_tap_e tap_next(input jsfa_tap_e s,
                                          input logic tms);
      case (s)
         TAP_RESET: tap_next = tms ? TAP_RESET : TAP_IDLE;
         TAP_IDLE: tap_next = tms ? TAP_SELDR : TAP_IDLE;
         TAP_SELDR: tap_next = tms ? TAP_SELIR : TAP_CAPDR;
         TAP_CAPDR: tap_next = tms ? TAP_EX1DR : TAP_SHDR;
         TAP_SHDR: tap_next = tms ? TAP_EX1DR : TAP_SHDR;
         TAP_EX1DR: tap_next = tms ? TAP_UPDR : TAP_PADR;
         TAP_PADR: tap_next = tms ? TAP_EX2DR : TAP_PADR;
         TAP_EX2DR: tap_next = tms ? TAP_UPDR : TAP_SHDR;
         TAP_UPDR: tap_next = tms ? TAP_SELDR : TAP_IDLE;
         TAP_SELIR: tap_next = tms ? TAP_RESET : TAP_CAPIR;
         TAP_CAPIR: tap_next = tms ? TAP_EX1IR : TAP_SHIR;
         TAP_SHIR: tap_next = tms ? TAP_EX1IR : TAP_SHIR;
         TAP_EX1IR: tap_next = tms ? TAP_UPIR : TAP_PAIR;
         TAP_PAIR: tap_next = tms ? TAP_EX2IR : TAP_PAIR;
         TAP_EX2IR: tap_next = tms ? TAP_UPIR : TAP_SHIR;
         TAP_UPIR: tap_next = tms ? TAP_SELDR : TAP_IDLE;
         default: tap_next = TAP_RESET;
      endcase
   endfunction

   // Bits in line order: byte [31:24] first, each byte from its bit 0
   function automatic logic [31:0] send_order(input logic [31:0] w);
      int i;
      send_order = 32'h0;
      for (i = 0; i < 32; i++) begin
         send_order[31-i] = w[(3 - i / 8) * 8 + i % 8];
      end
   endfunction

   // Left-align the low n bits of a field, last bit sent is bit 0
   function automatic logic [63:0] align(input logic [31:0] v,
                                         input logic [5:0] n);
      align = {32'h0, v} << (7'd64 - {1'b0, n});
   endfunction

   // TX word source: descriptor for one word, file otherwise
   function automatic logic [31:0] tx_word(input logic [FAW-1:0] idx);
      if (desc.tx_words == 7'h01) begin
         tx_word = desc.tx_data;
      end else begin
         tx_word = file_mem[idx];
      end
   endfunction

   // Bit count of a phase, zero means the phase is skipped
   function automatic logic [5:0] phase_len(input logic [2:0] ph);
      case (ph)
         `JSFA_PH_CMD: phase_len = {2'b00, desc.cmd_bits};
         `JSFA_PH_ADDR: phase_len = desc.addr_bits;
         `JSFA_PH_MODE: phase_len = {2'b00, desc.mode_bits};
         `JSFA_PH_DUMMY: phase_len = desc.dummy_bits;
         `JSFA_PH_TX: begin
            phase_len = (desc.tx_words != 7'h00) ? desc.tx_bits : 6'h00;
         end
         `JSFA_PH_RX: phase_len = desc.rx_bits;
         default: phase_len = 6'h00;
      endcase
   endfunction

   // Shift pattern of a phase; dummy and RX phases send zeros
   function automatic logic [63:0] phase_data(input logic [2:0] ph);
      case (ph)
         `JSFA_PH_CMD: phase_data = align({24'h0, desc.cmd},
                                          phase_len(ph));
         `JSFA_PH_ADDR: phase_data = align(desc.addr, phase_len(ph));
         `JSFA_PH_MODE: phase_data = align({24'h0, desc.mode},
                                           phase_len(ph));
         `JSFA_PH_TX: phase_data = {send_order(tx_word('0)), 32'h0};
         default: phase_data = 64'h0;
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // Crossings
   // ----------------------------------------------------------------------
   // Start toggle into the oscillator domain
   jsfa_sync #(.W(1)) u_start_sync (
      .clk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .d_i(start_tgl_r),
      .q_o(start_s)
   );

   // Completion toggle back to the test clock domain
   jsfa_sync #(.W(1)) u_done_sync (
      .clk_i(jtag_tck_i),
      .rst_n_i(rst_n_i),
      .d_i(done_tgl_r),
      .q_o(done_tgl_t)
   );

   // Mode pins and controller select are static straps, still synced
   jsfa_sync #(.W(3)) u_pins_sync (
      .clk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .d_i({config_mode_pins_i, active_controller_select_i}),
      .q_o(pins_s)
   );

   // Flash data input
   jsfa_sync #(.W(1)) u_miso_sync (
      .clk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .d_i(spi_miso_i),
      .q_o(miso_s)
   );

   // ----------------------------------------------------------------------
   // TAP controller
   // ----------------------------------------------------------------------
   // State follows TMS on each rising test clock
   always_ff @(posedge jtag_tck_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tap_r <= TAP_RESET;
      end else begin
         tap_r <= tap_next(tap_r, jtag_tms_i);
      end
   end

   // Instruction register, shifted LSB first
   always_ff @(posedge jtag_tck_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ir_r <= `JSFA_IR_BYPASS;
         ir_sh_r <= '0;
         prev_access_r <= 1'b0;
      end else begin
         case (tap_r)
            TAP_RESET: begin
               ir_r <= `JSFA_IR_BYPASS;
               prev_access_r <= 1'b0;
            end
            TAP_CAPIR: ir_sh_r <= `JSFA_IR_CAPTURE;
            TAP_SHIR: ir_sh_r <= {jtag_tdi_i, ir_sh_r[5:1]};
            TAP_UPIR: begin
               ir_r <= ir_sh_r;
               prev_access_r <= (ir_r == `JSFA_IR_ACCESS);
            end
            default: ir_r <= ir_r;
         endcase
      end
   end

   // Data register: width follows the current instruction
   always_ff @(posedge jtag_tck_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dr_r <= '0;
      end else if (tap_r == TAP_CAPDR) begin
         case (ir_r)
            `JSFA_IR_RXRB: begin
               dr_r <= {86'h0, rx_r, prev_access_r};
            end
            `JSFA_IR_BUSY: dr_r <= {118'h0, busy_t};
            default: dr_r <= '0;
         endcase
      end else if (tap_r == TAP_SHDR) begin
         case (ir_r)
            `JSFA_IR_ACCESS: dr_r <= {jtag_tdi_i, dr_r[118:1]};
            `JSFA_IR_PAGE: dr_r[31:0] <= {jtag_tdi_i, dr_r[31:1]};
            `JSFA_IR_RXRB: dr_r[32:0] <= {jtag_tdi_i, dr_r[32:1]};
            default: dr_r[0] <= jtag_tdi_i;
         endcase
      end
   end

   // Descriptor load; an update while busy is ignored
   always_ff @(posedge jtag_tck_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         desc_raw_r <= '0;
         start_tgl_r <= 1'b0;
      end else if (tap_r == TAP_UPDR && ir_r == `JSFA_IR_ACCESS &&
                   !busy_t) begin
         desc_raw_r <= dr_r;
         start_tgl_r <= ~start_tgl_r;
      end
   end

   // Page file: one word per update, cleared only by test-logic reset
   always_ff @(posedge jtag_tck_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         waddr_r <= '0;
         for (int k = 0; k < FILE_WORDS; k++) begin
            file_mem[k] <= 32'h0;
         end
      end else if (tap_r == TAP_RESET) begin
         waddr_r <= '0;
         for (int k = 0; k < FILE_WORDS; k++) begin
            file_mem[k] <= 32'h0;
         end
      end else if (tap_r == TAP_UPIR && ir_sh_r == `JSFA_IR_PAGE) begin
         waddr_r <= '0;
      end else if (tap_r == TAP_UPDR && ir_r == `JSFA_IR_PAGE &&
                   !busy_t) begin
         file_mem[waddr_r] <= dr_r[31:0];
         waddr_r <= waddr_r + 1'b1;
      end
   end

   // TDO changes on the falling test clock edge
   always_ff @(negedge jtag_tck_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         jtag_tdo_o <= 1'b0;
         jtag_tdo_oe_o <= 1'b0;
      end else begin
         jtag_tdo_o <= (tap_r == TAP_SHIR) ? ir_sh_r[0] : dr_r[0];
         jtag_tdo_oe_o <= (tap_r == TAP_SHIR) || (tap_r == TAP_SHDR);
      end
   end

   // ----------------------------------------------------------------------
   // SPI sequencer on the oscillator clock
   // ----------------------------------------------------------------------
   // Phase walk and bit timing; SCLK is never taken from the test clock
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sq_r <= SQ_IDLE;
         phase_r <= `JSFA_PH_CMD;
         bit_cnt_r <= '0;
         word_cnt_r <= '0;
         word_idx_r <= '0;
         sh_r <= '0;
         half_r <= '0;
         start_seen_r <= 1'b0;
         done_tgl_r <= 1'b0;
         spi_busy_o <= 1'b0;
         spi_cs_n_o <= 1'b1;
         spi_clk_o <= 1'b0;
         spi_mosi_o <= 1'b0;
      end else begin
         case (sq_r)
            SQ_IDLE: begin
               spi_clk_o <= cpol;
               spi_cs_n_o <= 1'b1;
               if (start_s != start_seen_r) begin
                  start_seen_r <= start_s;
                  spi_busy_o <= 1'b1;
                  phase_r <= `JSFA_PH_CMD;
                  sq_r <= SQ_LOAD;
               end
            end
            SQ_LOAD: begin
               half_r <= '0;
               if (phase_r == `JSFA_PH_END) begin
                  sq_r <= SQ_END;
               end else if (phase_len(phase_r) == 6'h00) begin
                  phase_r <= phase_r + 3'd1;
               end else begin
                  sh_r <= phase_data(phase_r);
                  bit_cnt_r <= phase_len(phase_r);
                  word_cnt_r <= desc.tx_words;
                  word_idx_r <= FAW'(1);
                  spi_cs_n_o <= 1'b0;
                  if (!cpha) begin
                     spi_mosi_o <= 1'(phase_data(phase_r) >> 63);
                  end
                  sq_r <= SQ_LEAD;
               end
            end
            SQ_LEAD: begin
               half_r <= half_end ? 8'h00 : half_r + 8'h01;
               if (half_end) begin
                  spi_clk_o <= ~cpol;
                  if (cpha) begin
                     spi_mosi_o <= sh_r[63];
                  end
                  sq_r <= SQ_TRAIL;
               end
            end
            SQ_TRAIL: begin
               half_r <= half_end ? 8'h00 : half_r + 8'h01;
               if (half_end) begin
                  spi_clk_o <= cpol;
                  sh_r <= sh_r << 1;
                  bit_cnt_r <= bit_cnt_r - 6'd1;
                  if (bit_cnt_r != 6'd1) begin
                     if (!cpha) begin
                        spi_mosi_o <= sh_r[62];
                     end
                     sq_r <= SQ_LEAD;
                  end else if (phase_r == `JSFA_PH_TX &&
                               word_cnt_r > 7'd1) begin
                     // Next file word; total is bits times words
                     sh_r <= {send_order(tx_word(word_idx_r)), 32'h0};
                     bit_cnt_r <= desc.tx_bits;
                     word_cnt_r <= word_cnt_r - 7'd1;
                     word_idx_r <= word_idx_r + 1'b1;
                     if (!cpha) begin
                        spi_mosi_o <= 1'(send_order(tx_word(word_idx_r))
                                         >> 31);
                     end
                     sq_r <= SQ_LEAD;
                  end else begin
                     phase_r <= phase_r + 3'd1;
                     sq_r <= SQ_LOAD;
                  end
               end
            end
            SQ_END: begin
               // Hold select one half period past the last edge
               half_r <= half_end ? 8'h00 : half_r + 8'h01;
               if (half_end) begin
                  spi_cs_n_o <= 1'b1;
                  spi_busy_o <= 1'b0;
                  done_tgl_r <= start_seen_r;
                  spi_mosi_o <= 1'b0;
                  sq_r <= SQ_IDLE;
               end
            end
            default: sq_r <= SQ_IDLE;
         endcase
      end
   end

   // RX capture on the sampling edge of the RX phase
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_r <= 32'h0;
      end else if (sq_r == SQ_IDLE && start_s != start_seen_r) begin
         rx_r <= 32'h0;
      end else if (phase_r == `JSFA_PH_RX && half_end &&
                   ((sq_r == SQ_LEAD && !cpha) ||
                    (sq_r == SQ_TRAIL && cpha))) begin
         rx_r <= {rx_r[30:0], miso_s};
      end
   end

   // Bus is driven only when strapped as active controller
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         spi_oe_o <= 1'b0;
      end else begin
         spi_oe_o <= pins_s[0 +: 1] == 1'b1;
      end
   end

endmodule // jsfa_top

//--- logic/jsfa_params.svh
// Constants of the JTAG-commanded SPI flash access sequencer
//
// Summary of operation
// - Transfer starts after data-register update state
// - SPI clock comes from internal oscillator
// - All four SPI modes, single line
// - Controller select high: device drives bus
// - Capture up to 32 RX bits for readback
// - 256-byte TX file filled by page load
// - File transfer sends bits times words
// - File kept until test-logic reset
// - Page load instruction clears write address
// - Command, address, mode counts at top
// - TX bit, TX word, dummy, RX counts
// - Command, mode value and address fields
// - TX word: big-endian bytes, little-endian bits
// - Page load takes 1 to 64 words
// - RX readback: 33 bits, valid in bit 0
// - Busy query: one bit, 1 when busy
// - Six-bit instruction register, LSB first
`ifndef JSFA_PARAMS_SVH
`define JSFA_PARAMS_SVH

// ----------------------------------------------------------------------
// Instruction register
// ----------------------------------------------------------------------
`define JSFA_IR_W 6
`define JSFA_IR_ACCESS 6'h01
`define JSFA_IR_PAGE 6'h02
`define JSFA_IR_RXRB 6'h03
`define JSFA_IR_BUSY 6'h04
`define JSFA_IR_BYPASS 6'h3f
`define JSFA_IR_CAPTURE 6'h01

// ----------------------------------------------------------------------
// Data register widths and file size
// ----------------------------------------------------------------------
`define JSFA_DESC_W 119
`define JSFA_RXRB_W 33
`define JSFA_WORD_W 32
`define JSFA_FILE_WORDS 64

// ----------------------------------------------------------------------
// SPI timing and phase indices
// ----------------------------------------------------------------------
`define JSFA_SPI_HALF 4
`define JSFA_PH_CMD 3'd0
`define JSFA_PH_ADDR 3'd1
`define JSFA_PH_MODE 3'd2
`define JSFA_PH_DUMMY 3'd3
`define JSFA_PH_TX 3'd4
`define JSFA_PH_RX 3'd5
`define JSFA_PH_END 3'd6

`endif

//--- logic/jsfa_pkg.sv
// Types shared by the SPI flash access sequencer
package jsfa_pkg;

   // TAP controller states
   typedef enum logic [15:0] {
      TAP_RESET = 16'h0001,
      TAP_IDLE = 16'h0002,
      TAP_SELDR = 16'h0004,
      TAP_CAPDR = 16'h0008,
      TAP_SHDR = 16'h0010,
      TAP_EX1DR = 16'h0020,
      TAP_PADR = 16'h0040,
      TAP_EX2DR = 16'h0080,
      TAP_UPDR = 16'h0100,
      TAP_SELIR = 16'h0200,
      TAP_CAPIR = 16'h0400,
      TAP_SHIR = 16'h0800,
      TAP_EX1IR = 16'h1000,
      TAP_PAIR = 16'h2000,
      TAP_EX2IR = 16'h4000,
      TAP_UPIR = 16'h8000
   } jsfa_tap_e;

   // SPI sequencer states
   typedef enum logic [4:0] {
      SQ_IDLE = 5'h01,
      SQ_LOAD = 5'h02,
      SQ_LEAD = 5'h04,
      SQ_TRAIL = 5'h08,
      SQ_END = 5'h10
   } jsfa_seq_e;

   // Access descriptor, bit 118 first
   typedef struct packed {
      logic [3:0] cmd_bits;
      logic [5:0] addr_bits;
      logic [3:0] mode_bits;
      logic [5:0] tx_bits;
      logic [6:0] tx_words;
      logic [5:0] dummy_bits;
      logic [5:0] rx_bits;
      logic [7:0] cmd;
      logic [7:0] mode;
      logic [31:0] addr;
      logic [31:0] tx_data;
   } jsfa_desc_s;

endpackage

//--- logic/jsfa_sync.sv
// Two-stage synchroniser for levels and toggles
`timescale 1ns/1ps
module jsfa_sync #(
   parameter int W = 1
) (
   // Destination clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_r <= '0;
         q_o <= '0;
      end else begin
         meta_r <= d_i;
         q_o <= meta_r;
      end
   end

endmodule // jsfa_sync

//--- testbench/jsfa_top_props.sv
// Checker for the SPI side of the flash access sequencer
`timescale 1ns/1ps
module jsfa_top_props #(
   parameter int SPI_HALF = 4
) (
   // Clock, reset and pins
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [1:0] config_mode_pins_i,
   input wire logic active_controller_select_i,
   // SPI side
   input wire logic spi_clk_o,
   input wire logic spi_cs_n_o,
   input wire logic spi_mosi_o,
   input wire logic spi_oe_o,
   input wire logic spi_busy_o
);
   logic [2:0] run_r;
   logic [11:0] cfg_r;
   logic [3:0] gap_r;
   logic clk_r;
   logic calm;
   // Pin history: outputs only follow pins once the synchroniser filled
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run_r <= 3'h0;
         cfg_r <= 12'h0;
      end else begin
         run_r <= (run_r == 3'h7) ? run_r : run_r + 3'h1;
         cfg_r <= {cfg_r[8:0], active_controller_select_i,
            config_mode_pins_i};
      end
   end
   assign calm = (run_r == 3'h7) &&
      (cfg_r == {4{active_controller_select_i, config_mode_pins_i}});
   // Cycles since the serial clock last moved, saturating
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gap_r <= 4'h0;
         clk_r <= 1'b0;
      end else begin
         gap_r <= (spi_clk_o != clk_r) ? 4'h0 : gap_r + {3'h0, gap_r != 4'hf};
         clk_r <= spi_clk_o;
      end
   end
   default clocking dc @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   // Edge on which the flash samples data in the selected mode
   sequence samp_edge;
      $changed(spi_clk_o) && !spi_cs_n_o && calm &&
         ((spi_clk_o != config_mode_pins_i[1]) ^ config_mode_pins_i[0]);
   endsequence
   AST_CS_BUSY: assert property (
      !spi_cs_n_o |-> spi_busy_o) else $error("select low while idle");
   AST_BUSY_END: assert property (
      $fell(spi_busy_o) |-> $rose(spi_cs_n_o)) else $error("busy end off");
   AST_CS_START: assert property (
      $fell(spi_cs_n_o) |-> $past(spi_busy_o)) else $error("select early");
   AST_CLK_IDLE: assert property (
      spi_cs_n_o && calm |-> spi_clk_o == config_mode_pins_i[1])
      else $error("serial clock idle level wrong");
   AST_OE: assert property (
      calm |-> spi_oe_o == active_controller_select_i)
      else $error("pin enable does not follow select");
   AST_CLK_IN_FRAME: assert property (
      $changed(spi_clk_o) && calm |-> !spi_cs_n_o)
      else $error("serial clock moved outside a frame");
   AST_HALF: assert property (
      $changed(spi_clk_o) && !spi_cs_n_o |-> gap_r >= SPI_HALF - 1)
      else $error("serial clock half period too short");
   AST_MOSI_SETUP: assert property (
      samp_edge |-> $stable(spi_mosi_o)) else $error("data moved at sample");
   cover property ($fell(spi_busy_o));
   cover property (samp_edge ##0 config_mode_pins_i == 2'h3);
   cover property ($fell(spi_cs_n_o) && spi_oe_o);
endmodule // jsfa_top_props

bind jsfa_top jsfa_top_props #(.SPI_HALF(SPI_HALF)) i_props (.mclk_i,
   .rst_n_i, .config_mode_pins_i, .active_controller_select_i, .spi_clk_o,
   .spi_cs_n_o, .spi_mosi_o, .spi_oe_o, .spi_busy_o);

//--- testbench/jsfa_flash_model.sv
// Behavioural SPI flash that counts, captures and answers bits
`timescale 1ns/1ps
module jsfa_flash_model #(
   parameter logic [63:0] RSP = 64'h0
) (
   // Oscillator and mode pins
   input wire logic mclk_i,
   input wire logic [1:0] mode_i,
   // SPI bus
   input wire logic spi_clk_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_mosi_i,
   output logic spi_miso_o,
   // Observations
   output int bit_cnt_o,
   output logic [7:0] cmd_o,
   output logic [31:0] last_o
);
   initial spi_miso_o = 1'b0;
   // Frame start: first answer bit is ready at select
   always @(negedge spi_cs_n_i) begin
      bit_cnt_o = 0;
      spi_miso_o = RSP[63];
   end
   // Sample on the sampling edge, move the answer on the other one
   always @(spi_clk_i) begin
      if (spi_cs_n_i === 1'b0) begin
         if ((spi_clk_i != mode_i[1]) ^ mode_i[0]) begin
            last_o = {last_o[30:0], spi_mosi_i};
            if (bit_cnt_o < 8) cmd_o = {cmd_o[6:0], spi_mosi_i};
            bit_cnt_o = bit_cnt_o + 1;
         end else begin
            spi_miso_o = RSP[63 - (bit_cnt_o % 64)];
         end
      end
   end
   // Released line has no fixed level, so keep it moving
   always @(posedge mclk_i) begin
      if (spi_cs_n_i) spi_miso_o <= ~spi_miso_o;
   end
endmodule // jsfa_flash_model

//--- testbench/test_jtag_spi_flash_access.sv
// Self-checking bench for the JTAG-commanded SPI flash sequencer
`timescale 1ns/1ps
module test_jtag_spi_flash_access;
   import jsfa_pkg::*;
   localparam logic [63:0] RSP = 64'hc3a5_5a3c_96e1_0ff0;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic jtag_tck_i = 1'b0;
   logic jtag_tms_i = 1'b1;
   logic jtag_tdi_i = 1'b0;
   logic [1:0] config_mode_pins_i = 2'h0;
   logic active_controller_select_i = 1'b0;
   logic spi_miso_i, jtag_tdo_o, jtag_tdo_oe_o, spi_clk_o, spi_cs_n_o;
   logic spi_mosi_o, spi_oe_o, spi_busy_o, tdo_q;
   int cnt, bad_count, checks;
   logic [7:0] cmd;
   logic [31:0] last;
   logic [127:0] rd;
   jsfa_desc_s dsc;
   logic [31:0] wd [0:4] = '{32'h0123_4567, 32'h89ab_cdef, 32'hf0e1_d2c3,
      32'h5a6b_7c8d, 32'h1e2d_3c4b};
   // Clocks: the test clock has an odd offset to keep phases unrelated
   initial forever #20 mclk_i = ~mclk_i;
   initial begin
      #1.7;
      forever #3 jtag_tck_i = ~jtag_tck_i;
   end
   jsfa_top i_dut (.mclk_i, .rst_n_i, .jtag_tck_i, .jtag_tms_i, .jtag_tdi_i,
      .jtag_tdo_o, .jtag_tdo_oe_o, .config_mode_pins_i,
      .active_controller_select_i, .spi_miso_i, .spi_clk_o, .spi_cs_n_o,
      .spi_mosi_o, .spi_oe_o, .spi_busy_o);
   jsfa_flash_model #(.RSP(RSP)) i_flash (.mclk_i, .mode_i(config_mode_pins_i),
      .spi_clk_i(spi_clk_o), .spi_cs_n_i(spi_cs_n_o), .spi_mosi_i(spi_mosi_o),
      .spi_miso_o(spi_miso_i), .bit_cnt_o(cnt), .cmd_o(cmd), .last_o(last));
   task automatic cmp(input string what, input logic [63:0] exp,
      input logic [63:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One test clock: drive after the falling edge, read TDO at the rise
   task automatic step(input logic t, input logic d);
      @(negedge jtag_tck_i);
      jtag_tms_i = t;
      jtag_tdi_i = d;
      @(posedge jtag_tck_i);
      tdo_q = jtag_tdo_o;
   endtask
   // Idle to idle scan of IR or DR, bit 0 first, ending with an update
   task automatic scan(input logic ir, input int n, input logic [127:0] din);
      rd = '0;
      step(1'b1, 1'b0);
      if (ir) step(1'b1, 1'b0);
      step(1'b0, 1'b0);
      step(1'b0, 1'b0);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i]);
         rd[i] = tdo_q;
      end
      cmp("tdo enable", 64'h1, jtag_tdo_oe_o);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
      cmp("tdo idle", 64'h0, jtag_tdo_oe_o);
   endtask
   task automatic wait_done();
      int i;
      for (i = 0; i < 50 && spi_busy_o !== 1'b1; i++) @(negedge mclk_i);
      cmp("busy start", 64'h1, spi_busy_o);
      for (i = 0; i < 3000 && spi_busy_o !== 1'b0; i++) @(negedge mclk_i);
      cmp("busy end", 64'h0, spi_busy_o);
   endtask
   // Wire order of a word: bytes high first, each byte bit 0 first
   function automatic logic [31:0] revb(input logic [31:0] w);
      for (int i = 0; i < 32; i++) revb[i ^ 7] = w[i];
   endfunction
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      #400000;
      bad_count++;
      finish_test();
   end
   initial begin
      repeat (20) @(negedge mclk_i);
      rst_n_i = 1'b1;
      repeat (5) @(negedge mclk_i);
      cmp("select idle", 64'h1, spi_cs_n_o);
      cmp("pins off", 64'h0, spi_oe_o);
      active_controller_select_i = 1'b1;
      repeat (5) @(negedge mclk_i);
      cmp("pins on", 64'h1, spi_oe_o);
      step(1'b0, 1'b0);
      // Direct access in every clock mode, then read back the answer
      for (int m = 0; m < 4; m++) begin
         @(negedge mclk_i);
         config_mode_pins_i = m[1:0];
         repeat (6) @(negedge mclk_i);
         cmp("clock idle", m[1], spi_clk_o);
         scan(1'b1, 6, 128'h04);
         scan(1'b0, 1, 128'h0);
         cmp("busy before access", 64'h0, rd[0]);
         scan(1'b1, 6, 128'h01);
         dsc = '{4'h8, 6'h18, 4'h8, 6'h10, 7'h01, 6'h08, 6'h08, 8'h0b, 8'h5a,
            32'h0000_a5c3, 32'h1234_5678};
         scan(1'b0, 119, {9'h0, dsc});
         wait_done();
         cmp("bit count", 64'd72, cnt);
         cmp("command", 64'h0b, cmd);
         scan(1'b1, 6, 128'h03);
         scan(1'b0, 33, 128'h0);
         cmp("rx readback", {24'h0, RSP[63:56], 1'b1}, rd[32:0]);
      end
      // Page file: two words, two more, then one word over the old page
      for (int p = 0; p < 3; p++) begin
         scan(1'b1, 6, 128'h02);
         for (int w = 2 * p; w < 2 * p + 2 - p / 2; w++) begin
            scan(1'b0, 32, {96'h0, wd[w]});
         end
         scan(1'b1, 6, 128'h01);
         dsc = '{4'h8, 6'h18, 4'h0, 6'h20, 7'h02, 6'h00, 6'h00, 8'h02, 8'h00,
            32'h0000_0100, wd[2 * p]};
         scan(1'b0, 119, {9'h0, dsc});
         scan(1'b1, 6, 128'h04);
         scan(1'b0, 1, 128'h0);
         cmp("busy query", 64'h1, rd[0]);
         wait_done();
         cmp("bit count", 64'd96, cnt);
         cmp("file word", revb(wd[p == 2 ? 3 : 2*p+1]), last);
         repeat (10) @(posedge jtag_tck_i);
         scan(1'b0, 1, 128'h0);
         cmp("busy query", 64'h0, rd[0]);
         scan(1'b1, 6, 128'h03);
         scan(1'b0, 33, 128'h0);
         cmp("rx valid", 64'h0, rd[0]);
      end
      finish_test();
   end
endmodule // test_jtag_spi_flash_access
